// file: logic/rcr_top.sv
// reset cause recording, start-up delay and bandgap reference enable
// Function
// - low reset pin resets core, even clockless
// - full time-out delay before processor starts
// - watchdog sets bit 3; POR or zero-write clears
// - brown-out sets bit 2; POR or zero-write clears
// - pin reset sets bit 1; POR or zero-write clears
// - POR sets bit 0; only zero-write clears
// - reference on when fuse, bandgap select, converter
// - converter enable alone powers the reference
`timescale 1ns/1ps
module rcr_top #(
  parameter int unsigned STARTUP_CYCLES = rcr_pkg::STARTUP_DELAY_CYC,
  parameter int unsigned REF_CYCLES = rcr_pkg::REF_STARTUP_CYC
) (
  // clock and power-on reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // reset sources and fuse
  input wire rcr_pkg::rcr_rst_src_s i_rst_src,
  input wire logic i_brownout_detect_fuse,
  // register port
  input wire rcr_pkg::rcr_bus_s i_bus,
  output rcr_pkg::rcr_byte_t o_rdata,
  // core and analog controls
  output logic o_cpu_reset,
  output logic o_reference_enable,
  output logic o_reference_ready,
  output logic o_comparator_bandgap_select,
  output logic o_converter_enable,
  // interrupt
  output logic o_irq
);
  import rcr_pkg::*;

  typedef struct packed {
    rcr_seq_e seq;
    logic cmp_bg;
    logic conv_en;
    logic ref_en;
    logic ref_rdy_q;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    rcr_byte_t rdata;
  } rcr_top_state_s;

  rcr_top_state_s state;
  rcr_top_state_s next_state;

  logic pin_low;
  logic rst_req;
  logic tout_run;
  logic tout_done;
  logic ref_ready;
  logic cause_wr;
  logic [3:0] cause;
  logic [3:0] events;
  rcr_byte_t rd_value;

  assign pin_low = ~i_rst_src.pin_n;
  assign rst_req = pin_low | i_rst_src.watchdog | i_rst_src.brownout;
  // the timer only runs once every source has let go
  assign tout_run = (state.seq == ST_DELAY) && !rst_req;
  assign cause_wr = i_bus.wr && (i_bus.addr == OFF_CAUSE);

  rcr_level_timer #(
    .CYCLES(STARTUP_CYCLES)
  ) u_tout_timer (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_run(tout_run),
    .o_done(tout_done)
  );

  // reference ready only after the worst-case start-up time
  rcr_level_timer #(
    .CYCLES(REF_CYCLES)
  ) u_ref_timer (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_run(state.ref_en),
    .o_done(ref_ready)
  );

  // power-on flag: survives every other reset kind
  rcr_cause_flag #(
    .RST_VAL(POR_FLAG_RST)
  ) u_por_flag (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_set(1'b0),
    .i_clear(cause_wr && !i_bus.wdata[BIT_POR]),
    .o_flag(cause[BIT_POR])
  );

  rcr_cause_flag #(
    .RST_VAL(CAUSE_FLAG_RST)
  ) u_pin_flag (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_set(pin_low),
    .i_clear(cause_wr && !i_bus.wdata[BIT_PIN]),
    .o_flag(cause[BIT_PIN])
  );

  rcr_cause_flag #(
    .RST_VAL(CAUSE_FLAG_RST)
  ) u_brownout_flag (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_set(i_rst_src.brownout),
    .i_clear(cause_wr && !i_bus.wdata[BIT_BROWNOUT]),
    .o_flag(cause[BIT_BROWNOUT])
  );

  rcr_cause_flag #(
    .RST_VAL(CAUSE_FLAG_RST)
  ) u_wdt_flag (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_set(i_rst_src.watchdog),
    .i_clear(cause_wr && !i_bus.wdata[BIT_WDT]),
    .o_flag(cause[BIT_WDT])
  );

  always_comb begin
    events = 4'h0;
    events[IRQ_PIN] = pin_low;
    events[IRQ_BROWNOUT] = i_rst_src.brownout;
    events[IRQ_WDT] = i_rst_src.watchdog;
    events[IRQ_REF] = ref_ready && !state.ref_rdy_q;
  end

  always_comb begin
    rd_value = 8'h00;
    case (i_bus.addr)
      OFF_CAUSE: begin
        rd_value[3:0] = cause;
      end
      OFF_CMP_CTRL: begin
        rd_value[BIT_CMP_BG] = state.cmp_bg;
      end
      OFF_CONV_CTRL: begin
        rd_value[BIT_CONV_EN] = state.conv_en;
      end
      OFF_IRQ_STAT: begin
        rd_value[3:0] = state.irq_stat;
      end
      OFF_IRQ_MASK: begin
        rd_value[3:0] = state.irq_mask;
      end
      OFF_SEQ_STAT: begin
        rd_value[BIT_REF_READY] = ref_ready;
        rd_value[BIT_CPU_RUN] = (state.seq == ST_RUN);
      end
      default: begin
        rd_value = 8'h00;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    // start-up sequencer
    case (state.seq)
      ST_HOLD: begin
        if (!rst_req) begin
          next_state.seq = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (rst_req) begin
          next_state.seq = ST_HOLD;
        end else if (tout_done) begin
          next_state.seq = ST_RUN;
        end
      end
      ST_RUN: begin
        if (rst_req) begin
          next_state.seq = ST_HOLD;
        end
      end
      default: begin
        next_state.seq = ST_HOLD;
      end
    endcase
    // control writes
    if (i_bus.wr && i_bus.addr == OFF_CMP_CTRL) begin
      next_state.cmp_bg = i_bus.wdata[BIT_CMP_BG];
    end
    if (i_bus.wr && i_bus.addr == OFF_CONV_CTRL) begin
      next_state.conv_en = i_bus.wdata[BIT_CONV_EN];
    end
    if (i_bus.wr && i_bus.addr == OFF_IRQ_MASK) begin
      next_state.irq_mask = i_bus.wdata[3:0];
    end
    // write-one-to-clear, a new event wins over the clear
    if (i_bus.wr && i_bus.addr == OFF_IRQ_STAT) begin
      next_state.irq_stat = state.irq_stat & ~i_bus.wdata[3:0];
    end
    next_state.irq_stat = next_state.irq_stat | events;
    next_state.ref_en = i_brownout_detect_fuse | state.cmp_bg | state.conv_en;
    next_state.ref_rdy_q = ref_ready;
    // read data stand for exactly one cycle
    next_state.rdata = i_bus.rd ? rd_value : 8'h00;
    if (i_reset) begin
      next_state.seq = ST_HOLD;
      next_state.cmp_bg = CTRL_BIT_RST;
      next_state.conv_en = CTRL_BIT_RST;
      next_state.ref_en = CTRL_BIT_RST;
      next_state.ref_rdy_q = 1'b0;
      next_state.irq_stat = IRQ_RST;
      next_state.irq_mask = IRQ_RST;
      next_state.rdata = 8'h00;
    end
  end

  always_ff @(posedge i_mclk) begin
    state <= next_state;
  end

  // pin path is combinational so a stopped clock still resets the core
  assign o_cpu_reset = i_reset | pin_low | (state.seq != ST_RUN);
  assign o_rdata = state.rdata;
  assign o_reference_enable = state.ref_en;
  assign o_reference_ready = ref_ready;
  assign o_comparator_bandgap_select = state.cmp_bg;
  assign o_converter_enable = state.conv_en;
  assign o_irq = |(state.irq_stat & state.irq_mask);

  // helper counters read only by the checks below
  logic [15:0] chk_run_cnt;
  logic [15:0] chk_low_cnt;

  always_ff @(posedge i_mclk) begin
    if (i_reset || !tout_run) begin
      chk_run_cnt <= 16'h0000;
    end else begin
      chk_run_cnt <= chk_run_cnt + 16'h0001;
    end
    if (i_reset || !pin_low) begin
      chk_low_cnt <= 16'h0000;
    end else if (chk_low_cnt != 16'hffff) begin
      chk_low_cnt <= chk_low_cnt + 16'h0001;
    end
  end

  default clocking chk_clk @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  AST_PIN_HOLDS_CORE: assert property (
    pin_low |-> o_cpu_reset ##1 (o_cpu_reset && state.seq != ST_RUN))
    else $error("pin low did not hold the core in reset");

  AST_LONG_PULSE_RESETS: assert property (
    (chk_low_cnt >= 16'(PIN_PULSE_CYC)) |-> (state.seq == ST_HOLD && cause[BIT_PIN]))
    else $error("long pin pulse did not reach reset and cause flag");

  AST_FULL_TIMEOUT: assert property (
    (state.seq == ST_DELAY && $past(state.seq) == ST_DELAY && next_state.seq == ST_RUN)
      |-> (chk_run_cnt == 16'(STARTUP_CYCLES)))
    else $error("processor released before the full time-out");

  AST_RESERVED_ZERO: assert property (
    (i_bus.rd && i_bus.addr == OFF_CAUSE) |=> (o_rdata[7:4] == 4'h0 && o_rdata[3:0] == $past(cause)))
    else $error("cause read shows wrong value or reserved bits");

  AST_WDT_SET_CLR: assert property (
    (i_rst_src.watchdog |=> cause[BIT_WDT])
    and ((cause_wr && !i_bus.wdata[BIT_WDT] && !i_rst_src.watchdog) |=> !cause[BIT_WDT]))
    else $error("watchdog flag not set or not cleared");

  AST_BROWNOUT_SET_CLR: assert property (
    (i_rst_src.brownout |=> cause[BIT_BROWNOUT])
    and ((cause_wr && !i_bus.wdata[BIT_BROWNOUT] && !i_rst_src.brownout) |=> !cause[BIT_BROWNOUT]))
    else $error("brown-out flag not set or not cleared");

  AST_PIN_SET: assert property (
    pin_low |=> cause[BIT_PIN])
    else $error("pin reset flag not set");

  AST_POR_AFTER_RESET: assert property (
    $fell(i_reset) |-> (cause == 4'b0001))
    else $error("power-on reset left wrong cause flags");

  AST_POR_KEPT: assert property (
    (cause[BIT_POR] && !(cause_wr && !i_bus.wdata[BIT_POR])) |=> cause[BIT_POR])
    else $error("power-on flag lost without a zero write");

  AST_WRITE_ONE_KEEPS: assert property (
    (cause_wr && i_bus.wdata[3:0] == 4'hf && !rst_req) |=> (cause == $past(cause)))
    else $error("writing ones changed a cause flag");

  AST_REF_FOLLOWS: assert property (
    (!i_brownout_detect_fuse && !state.cmp_bg && !state.conv_en) [*2] |-> !o_reference_enable)
    else $error("reference stayed on with no enable condition");

  AST_CONV_POWERS_REF: assert property (
    state.conv_en |=> o_reference_enable)
    else $error("converter enable did not power the reference");

  AST_REF_READY_LATE: assert property (
    $rose(ref_ready) |-> $past(state.ref_en, 2))
    else $error("reference ready without a running reference");

  COV_WDT_RESTART: cover property (
    i_rst_src.watchdog ##[1:8] (state.seq == ST_DELAY) ##[1:1000] (state.seq == ST_RUN));

  COV_PIN_RESET: cover property ($fell(i_rst_src.pin_n) ##1 cause[BIT_PIN]);

  COV_REF_READY: cover property ($rose(state.conv_en) ##[1:1000] $rose(ref_ready));

  COV_IRQ: cover property ($rose(o_irq));
endmodule

// file: shared/rcr_pkg.sv
// shared constants, carriers and state codes of the reset cause and reference enable block
package rcr_pkg;
  // clock rate and timing figures
  localparam int CLK_MHZ = 250;
  localparam int PIN_PULSE_NS = 500;
  localparam int PIN_PULSE_CYC = (PIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_STARTUP_NS = 10000;
  localparam int REF_STARTUP_CYC = (REF_STARTUP_NS * CLK_MHZ + 999) / 1000;
  // time-out period is a plain default; small benches override it
  localparam int STARTUP_DELAY_NS = 16000;
  localparam int STARTUP_DELAY_CYC = (STARTUP_DELAY_NS * CLK_MHZ + 999) / 1000;

  // register offsets
  localparam logic [7:0] OFF_CMP_CTRL = 8'h08;
  localparam logic [7:0] OFF_CAUSE = 8'h34;
  localparam logic [7:0] OFF_CONV_CTRL = 8'h40;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h41;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h42;
  localparam logic [7:0] OFF_SEQ_STAT = 8'h43;

  // field positions
  localparam int BIT_POR = 0;
  localparam int BIT_PIN = 1;
  localparam int BIT_BROWNOUT = 2;
  localparam int BIT_WDT = 3;
  localparam int BIT_CMP_BG = 6;
  localparam int BIT_CONV_EN = 0;
  localparam int BIT_REF_READY = 0;
  localparam int BIT_CPU_RUN = 1;
  localparam int IRQ_PIN = 0;
  localparam int IRQ_BROWNOUT = 1;
  localparam int IRQ_WDT = 2;
  localparam int IRQ_REF = 3;

  // values after reset
  localparam logic POR_FLAG_RST = 1'b1;
  localparam logic CAUSE_FLAG_RST = 1'b0;
  localparam logic CTRL_BIT_RST = 1'b0;
  localparam logic [3:0] IRQ_RST = 4'h0;

  typedef logic [7:0] rcr_byte_t;

  typedef struct packed {
    rcr_byte_t addr;
    rcr_byte_t wdata;
    logic wr;
    logic rd;
  } rcr_bus_s;

  typedef struct packed {
    logic pin_n;
    logic watchdog;
    logic brownout;
  } rcr_rst_src_s;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b11
  } rcr_seq_e;
endpackage

// file: logic/rcr_cause_flag.sv
// one sticky reset cause flag: hardware set, software write-zero clear
`timescale 1ns/1ps
module rcr_cause_flag #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // set and clear
  input wire logic i_set,
  input wire logic i_clear,
  // flag
  output logic o_flag
);
  import rcr_pkg::*;

  typedef struct packed {
    logic flag;
  } rcr_flag_state_s;

  rcr_flag_state_s state;
  rcr_flag_state_s next_state;

  always_comb begin
    next_state = state;
    // set wins over a clear in the same cycle
    if (i_set) begin
      next_state.flag = 1'b1;
    end else if (i_clear) begin
      next_state.flag = 1'b0;
    end
    if (i_reset) begin
      next_state.flag = RST_VAL;
    end
  end

  always_ff @(posedge i_mclk) begin
    state <= next_state;
  end

  assign o_flag = state.flag;
endmodule

// file: logic/rcr_level_timer.sv
// counts cycles while a level holds; done after CYCLES such cycles
`timescale 1ns/1ps
module rcr_level_timer #(
  parameter int unsigned CYCLES = 16,
  parameter int unsigned W = $clog2(CYCLES + 1)
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // level and result
  input wire logic i_run,
  output logic o_done
);
  import rcr_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } rcr_timer_state_s;

  rcr_timer_state_s state;
  rcr_timer_state_s next_state;

  always_comb begin
    next_state = state;
    if (!i_run || i_reset) begin
      next_state.cnt = '0;
      next_state.done = 1'b0;
    end else if (!state.done) begin
      next_state.cnt = state.cnt + W'(1);
      next_state.done = (state.cnt == W'(CYCLES - 1));
    end
  end

  always_ff @(posedge i_mclk) begin
    state <= next_state;
  end

  assign o_done = state.done;
endmodule

// file: sim/rcr_pin_model.sv
// board reset source driving the active-low reset pin
`timescale 1ns/1ps
module rcr_pin_model (
  // clock and command
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [7:0] i_len,
  // reset pin
  output logic o_pin_n
);
  logic [7:0] left = 8'h00;
  // pin has a pull-up, so a released pin reads high
  assign o_pin_n = (left == 8'h00);
  always @(posedge i_mclk) begin
    if (i_go) begin
      left <= i_len; // low level held for the whole pulse
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
endmodule

// file: sim/tb_rcr_top.sv
// self-checking bench of the reset cause and reference enable block
`timescale 1ns/1ps
module tb_rcr_top;
  import rcr_pkg::*;
  localparam int STUP = 8;
  localparam int REFC = 8;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic wdt = 1'b0;
  logic brownout_detector = 1'b0;
  logic fuse = 1'b0;
  logic pin_go = 1'b0;
  logic [7:0] pin_len = 8'h04;
  logic pin_n;
  rcr_bus_s bus = '0;
  rcr_rst_src_s src;
  rcr_byte_t o_rdata;
  rcr_byte_t rd;
  rcr_byte_t cause;
  rcr_byte_t tbl [5] = '{8'hf7, 8'hfb, 8'hff, 8'hfd, 8'hfe};
  logic cpu_rst, ref_en, ref_rdy, bg, conv, irq;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic [15:0] seed = 16'h8a02;

  assign src = '{pin_n: pin_n, watchdog: wdt, brownout: brownout_detector};
  always #2 i_mclk = ~i_mclk;

  rcr_top #(.STARTUP_CYCLES(STUP), .REF_CYCLES(REFC)) dut (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_rst_src(src), .i_brownout_detect_fuse(fuse), .i_bus(bus), .o_rdata(o_rdata),
    .o_cpu_reset(cpu_rst), .o_reference_enable(ref_en), .o_reference_ready(ref_rdy),
    .o_comparator_bandgap_select(bg), .o_converter_enable(conv), .o_irq(irq));
  rcr_pin_model pin (.i_mclk(i_mclk), .i_go(pin_go), .i_len(pin_len), .o_pin_n(pin_n));

  function automatic logic [15:0] xs(input logic [15:0] x);
    logic [15:0] y;
    y = x ^ (x << 7);
    y = y ^ (y >> 9);
    return y ^ (y << 8);
  endfunction

  // reserved bits stay zero; a one written keeps the flag
  function automatic rcr_byte_t cause_after_wr(input rcr_byte_t old, input rcr_byte_t wd);
    return old & wd & 8'h0f;
  endfunction

  task automatic final_report();
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk8(input rcr_byte_t got, input rcr_byte_t exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input rcr_byte_t a, input rcr_byte_t d);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_reg(input rcr_byte_t a, output rcr_byte_t d);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus.rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic por();
    int k;
    @(posedge i_mclk);
    i_reset <= 1'b1;
    repeat (5) @(posedge i_mclk);
    i_reset <= 1'b0;
    k = 0;
    @(posedge i_mclk);
    #1;
    while (cpu_rst === 1'b1 && k < 100) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    chk1(k >= STUP && k <= STUP + 3, 1'b1);
  endtask

  task automatic evt(input int which);
    @(posedge i_mclk);
    if (which == 0) begin
      wdt <= 1'b1;
    end else begin
      brownout_detector <= 1'b1;
    end
    @(posedge i_mclk);
    wdt <= 1'b0;
    brownout_detector <= 1'b0;
  endtask

  // longer than the guaranteed 125 cycles of a valid pin reset
  task automatic pin_pulse();
    @(posedge i_mclk);
    pin_len <= 8'd130;
    pin_go <= 1'b1;
    @(posedge i_mclk);
    pin_go <= 1'b0;
    #1;
    chk1(cpu_rst, 1'b1);
    repeat (132) @(posedge i_mclk);
  endtask

  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      final_report();
    end
  end

  initial begin
    por();
    rd_reg(OFF_CAUSE, rd);
    chk8(rd, 8'h01);
    @(posedge i_mclk);
    #1;
    chk8(o_rdata, 8'h00);
    wr_reg(8'h77, 8'h00);
    rd_reg(8'h77, rd);
    chk8(rd, 8'h00);
    wr_reg(OFF_IRQ_MASK, 8'h00);
    pin_pulse();
    chk1(irq, 1'b0);
    rd_reg(OFF_CAUSE, rd);
    chk8(rd, 8'h03);
    rd_reg(OFF_IRQ_STAT, rd);
    chk8(rd & 8'h01, 8'h01);
    wr_reg(OFF_IRQ_MASK, 8'h01);
    #1;
    chk1(irq, 1'b1);
    wr_reg(OFF_IRQ_STAT, 8'h01);
    #1;
    chk1(irq, 1'b0);
    evt(0);
    evt(1);
    rd_reg(OFF_CAUSE, rd);
    chk8(rd, 8'h0f);
    cause = 8'h0f;
    for (n = 0; n < 5; n++) begin
      wr_reg(OFF_CAUSE, tbl[n]);
      cause = cause_after_wr(cause, tbl[n]);
      rd_reg(OFF_CAUSE, rd);
      chk8(rd, cause);
    end
    // other reset kinds leave the power-on flag cleared
    evt(0);
    rd_reg(OFF_CAUSE, rd);
    chk8(rd, 8'h08);
    cause = 8'h08;
    for (n = 0; n < 24; n++) begin
      seed = xs(seed);
      if (seed[1:0] == 2'b00) begin
        evt(seed[2]);
        cause = cause | (seed[2] ? 8'h04 : 8'h08);
      end else if (seed[1:0] == 2'b01) begin
        pin_pulse();
        cause = cause | 8'h02;
      end else begin
        wr_reg(OFF_CAUSE, seed[15:8]);
        cause = cause_after_wr(cause, seed[15:8]);
      end
      rd_reg(OFF_CAUSE, rd);
      chk8(rd, cause);
    end
    por();
    rd_reg(OFF_CAUSE, rd);
    chk8(rd, 8'h01);
    wr_reg(OFF_CAUSE, 8'h00);
    rd_reg(OFF_CAUSE, rd);
    chk8(rd, 8'h00);
    rd_reg(OFF_SEQ_STAT, rd);
    chk8(rd, 8'h02);
    for (n = 0; n < 8; n++) begin
      wr_reg(OFF_CMP_CTRL, {1'b0, n[1], 6'h00});
      wr_reg(OFF_CONV_CTRL, {7'h00, n[2]});
      fuse <= n[0];
      repeat (2) @(posedge i_mclk);
      #1;
      chk1(ref_en, |n[2:0]);
      chk1(bg, n[1]);
      chk1(conv, n[2]);
    end
    // software waits out the start-up time before trusting the reference
    repeat (REFC + 4) @(posedge i_mclk);
    #1;
    chk1(ref_rdy, 1'b1);
    rd_reg(OFF_IRQ_STAT, rd);
    chk8(rd & 8'h08, 8'h08);
    wr_reg(OFF_CONV_CTRL, 8'h00);
    wr_reg(OFF_CMP_CTRL, 8'h00);
    fuse <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
    chk1(ref_en, 1'b0);
    chk1(ref_rdy, 1'b0);
    // converter alone: ready exactly after the start-up count, not one cycle early
    wr_reg(OFF_CONV_CTRL, 8'h01);
    repeat (REFC) @(posedge i_mclk);
    #1;
    chk1(ref_rdy, 1'b0);
    @(posedge i_mclk);
    #1;
    chk1(ref_rdy, 1'b1);
    rd_reg(OFF_CONV_CTRL, rd);
    chk8(rd, 8'h01);
    rd_reg(OFF_SEQ_STAT, rd);
    chk8(rd, 8'h03);
    final_report();
  end
endmodule
